/* cc_unit_asserts.sv */
// port assertions for the capture/compare unit
`timescale 1ns/1ns
module cc_unit_checker (
  input logic        ref_clk, // clock
  input logic        rst_n,   // reset, active low
  input logic        psel,    // apb select
  input logic        penable, // apb access
  input logic        pwrite,  // apb write
  input logic [7:0]  paddr,   // apb address
  input logic [31:0] pwdata,  // apb write data
  input logic [31:0] prdata,  // apb read data
  input logic        pready,  // apb ready
  input logic        pslverr, // apb error
  input logic [7:0]  pinIn,   // pin levels
  input logic [7:0]  pinOut,  // pin drive
  input logic [7:0]  pinOe,   // pin enables
  input logic        irq      // interrupt
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire wrDone = psel && penable && pready && pwrite;
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (pready && paddr > 8'h44 |-> pslverr)
    else $error("no error on unmapped address");
  a_err_mapped: assert property (pready && paddr <= 8'h44 &&
    paddr[1:0] == 2'h0 |-> !pslverr) else $error("error on mapped address");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_reset_quiet: assert property ($rose(rst_n) |-> pinOe == 8'h00 && !irq)
    else $error("outputs active after reset");
  a_rdata_hold: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("read data moved outside a read");
  a_oe_by_write: assert property ($changed(pinOe) |->
    $past(wrDone) || $past(wrDone, 2)) else $error("enable moved alone");
  a_irq_masked: assert property (wrDone && paddr == 8'h44 &&
    pwdata[9:0] == 10'h000 |-> ##2 !irq) else $error("irq with mask clear");
endmodule

/* cc_unit_defs.vh */
// register map, field layout, reset values and timing for the cc unit
`ifndef CC_UNIT_DEFS_VH
`define CC_UNIT_DEFS_VH

// byte addresses on the apb bus
`define CC_ADDR_TCTRL   8'h00
`define CC_ADDR_TB0CNT  8'h04
`define CC_ADDR_TB0RLD  8'h08
`define CC_ADDR_TB1CNT  8'h0c
`define CC_ADDR_TB1RLD  8'h10
`define CC_ADDR_MODE0   8'h14
`define CC_ADDR_MODE1   8'h18
`define CC_ADDR_DBL     8'h1c
`define CC_ADDR_CH0     8'h20
`define CC_ADDR_CH7     8'h3c
`define CC_ADDR_IRQST   8'h40
`define CC_ADDR_IRQMSK  8'h44

// timer control fields, per time base t at bit t*TCTRL_STRIDE
`define CC_TCTRL_STRIDE 8
`define CC_TCTRL_RUN    0
`define CC_TCTRL_PRE_LO 1
`define CC_PRE_W        3

// channel mode field: 4 bits per channel, 4 channels per mode word
`define CC_FLD_W        4
`define CC_FLD_TBSEL    3
`define CC_M_OFF        3'h0
`define CC_M_CAP_RISE   3'h1
`define CC_M_CAP_FALL   3'h2
`define CC_M_CAP_BOTH   3'h3
`define CC_M_CMP0       3'h4
`define CC_M_CMP1       3'h5
`define CC_M_CMP2       3'h6
`define CC_M_CMP3       3'h7

// status bits: channels 0..7, then time base overflows
`define CC_ST_W         10
`define CC_ST_OVF0      8
`define CC_ST_OVF1      9

// reset values
`define CC_RST_TCTRL    16'h0000
`define CC_RST_WORD     16'h0000
`define CC_RST_DBL      4'h0
`define CC_RST_ST       10'h000

// resolution: 16 base clock units, one unit is half a clock period
`define CC_RES_TCL      16
`define CC_RES_CYCLES   (`CC_RES_TCL / 2)
`define CC_DIV_W        11

`endif

/* eight_channel_cc_unit.v */
// eight-channel capture/compare unit with two reloadable time bases
`timescale 1ns/1ns
`include "cc_unit_defs.vh"

// Behaviour
// - eight capture/compare channels, finest step sixteen base clock units
// - two independent 16-bit time bases, each with its own reload register
// - each channel selects its time base and capture or compare operation
// - each channel owns one pin: capture trigger input or compare output
// - capture event latches the assigned time base count into the channel
// - every capture event raises that channel's interrupt request
// - capture trigger selectable as rising, falling or either edge
// - compare channels match continuously against their time base and act
// - compare mode 0: interrupt only, several per period, pin untouched
// - compare mode 1: each match toggles the pin, several per period
// - compare mode 2: interrupt only, at most one per period
// - compare mode 3: match sets pin, overflow clears it, once per period
// - double mode pairs channel i and i+4 on pin i, one toggle per cycle with a match on either
module eight_channel_cc_unit #(
  parameter RES_CYCLES = `CC_RES_CYCLES  // clocks per finest count step
) (
  input  wire        ref_clk,  // 100 MHz clock
  input  wire        rst_n,    // synchronous reset, active low
  input  wire        psel,     // apb select
  input  wire        penable,  // apb access phase
  input  wire        pwrite,   // apb write
  input  wire [7:0]  paddr,    // apb byte address
  input  wire [31:0] pwdata,   // apb write data
  output reg  [31:0] prdata,   // apb read data
  output reg         pready,   // apb ready
  output reg         pslverr,  // apb error on unmapped address
  input  wire [7:0]  pinIn,    // channel pin levels
  output wire [7:0]  pinOut,   // channel pin drive values
  output wire [7:0]  pinOe,    // channel pin drive enables
  output reg         irq       // level interrupt
);

  reg  [15:0]          tctrl_r;
  reg  [15:0]          mode0_r;
  reg  [15:0]          mode1_r;
  reg  [3:0]           dbl_r;
  reg  [`CC_ST_W-1:0]  status_r;
  reg  [`CC_ST_W-1:0]  mask_r;
  reg  [`CC_ST_W-1:0]  status_nxt;
  reg  [31:0]          rdData;
  reg                  rdErr;
  wire [31:0]          cntAll;
  wire [31:0]          rldAll;
  wire [1:0]           newVal;
  wire [1:0]           ovf;
  wire [127:0]         ccAll;
  wire [7:0]           chEvt;
  wire [7:0]           fireV;
  wire                 access;
  wire                 wrAcc;

  function isAddr;
    input [7:0] a;
    input [7:0] off;
    begin
      isAddr = (a == off);
    end
  endfunction

  assign access = psel & penable & pready;
  assign wrAcc  = access & pwrite;

  // apb slave: one wait state, pready from a flop
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & rdErr;
      if (psel & penable & ~pready & ~pwrite) begin
        prdata <= rdData;
      end
    end
  end

  // time bases
  genvar t;
  generate
    for (t = 0; t < 2; t = t + 1) begin : tb
      localparam [7:0] CNT_OFF = (t == 0) ? `CC_ADDR_TB0CNT : `CC_ADDR_TB1CNT;
      localparam [7:0] RLD_OFF = (t == 0) ? `CC_ADDR_TB0RLD : `CC_ADDR_TB1RLD;
      localparam integer BASE  = t * `CC_TCTRL_STRIDE;
      localparam [`CC_DIV_W-1:0] RES_W = RES_CYCLES;
      reg  [15:0]           cnt_r;
      reg  [15:0]           rld_r;
      reg  [`CC_DIV_W-1:0]  div_r;
      reg                   new_r;
      reg                   ovf_r;
      wire                  run;
      wire [`CC_PRE_W-1:0]  pre;
      wire [`CC_DIV_W-1:0]  divEnd;
      wire                  tick;
      assign run    = tctrl_r[BASE + `CC_TCTRL_RUN];
      assign pre    = tctrl_r[BASE + `CC_TCTRL_PRE_LO +: `CC_PRE_W];
      assign divEnd = (RES_W << pre) - 1'b1;
      assign tick   = run & (div_r == divEnd);
      always @(posedge ref_clk) begin
        if (!rst_n) begin
          cnt_r <= `CC_RST_WORD;
          rld_r <= `CC_RST_WORD;
          div_r <= {`CC_DIV_W{1'b0}};
          new_r <= 1'b0;
          ovf_r <= 1'b0;
        end else begin
          div_r <= (!run || tick) ? {`CC_DIV_W{1'b0}} : div_r + 1'b1;
          new_r <= 1'b0;
          ovf_r <= 1'b0;
          if (wrAcc && isAddr(paddr, RLD_OFF)) begin
            rld_r <= pwdata[15:0];
          end
          if (wrAcc && isAddr(paddr, CNT_OFF)) begin
            cnt_r <= pwdata[15:0];
            new_r <= 1'b1;
          end else if (tick) begin
            new_r <= 1'b1;
            if (cnt_r == 16'hffff) begin
              cnt_r <= rld_r;
              ovf_r <= 1'b1;
            end else begin
              cnt_r <= cnt_r + 16'h0001;
            end
          end
        end
      end
      assign cntAll[t*16 +: 16] = cnt_r;
      assign rldAll[t*16 +: 16] = rld_r;
      assign newVal[t] = new_r;
      assign ovf[t]    = ovf_r;
    end
  endgenerate

  // channels; pin i belongs to channel i
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : ch
      localparam [7:0]   CH_OFF = `CC_ADDR_CH0 + 4 * i;
      localparam integer SH     = (i % 4) * `CC_FLD_W;
      localparam integer PR     = (i < 4) ? i + 4 : i - 4;
      reg  [15:0] val_r;
      reg         done_r;
      reg         prev_r;
      reg         out_r;
      reg         oe_r;
      wire [3:0]  fld;
      wire [2:0]  m;
      wire        tbSel;
      wire [15:0] tcnt;
      wire        nv;
      wire        ov;
      wire        rise;
      wire        fall;
      wire        cap;
      wire        match;
      wire        once;
      wire        fire;
      wire        dblOwn;
      wire        dblLost;
      wire        tgl;
      assign fld   = (i < 4) ? mode0_r[SH +: 4] : mode1_r[SH +: 4];
      assign m     = fld[2:0];
      assign tbSel = fld[`CC_FLD_TBSEL];
      assign tcnt  = tbSel ? cntAll[31:16] : cntAll[15:0];
      assign nv    = tbSel ? newVal[1] : newVal[0];
      assign ov    = tbSel ? ovf[1] : ovf[0];
      assign rise  = pinIn[i] & ~prev_r;
      assign fall  = ~pinIn[i] & prev_r;
      assign cap   = ((m == `CC_M_CAP_RISE) & rise) |
                     ((m == `CC_M_CAP_FALL) & fall) |
                     ((m == `CC_M_CAP_BOTH) & (rise | fall));
      assign match = m[2] & nv & (tcnt == val_r);
      assign once  = (m == `CC_M_CMP2) | (m == `CC_M_CMP3);
      assign fire  = match & ~(once & done_r & ~ov);
      assign dblOwn  = (i < 4) & dbl_r[i % 4];
      assign dblLost = (i >= 4) & dbl_r[i % 4];
      assign tgl   = dblOwn ? ((fire & m[2]) | fireV[PR])
                            : (fire & (m == `CC_M_CMP1));
      always @(posedge ref_clk) begin
        if (!rst_n) begin
          val_r  <= `CC_RST_WORD;
          done_r <= 1'b0;
          prev_r <= 1'b0;
          out_r  <= 1'b0;
          oe_r   <= 1'b0;
        end else begin
          prev_r <= pinIn[i];
          if (cap) begin
            val_r <= tcnt;
          end else if (wrAcc && isAddr(paddr, CH_OFF)) begin
            val_r <= pwdata[15:0];
          end
          if (fire) begin
            done_r <= 1'b1;
          end else if (ov) begin
            done_r <= 1'b0;
          end
          // drive for compare modes 1 and 3 and for a double-mode owner in any mode; a double-mode partner floats
          oe_r <= ~dblLost & (dblOwn | (m == `CC_M_CMP1) |
                  (m == `CC_M_CMP3));
          if (dblLost) begin
            out_r <= out_r;
          end else if (tgl) begin
            out_r <= ~out_r;
          end else if (!dblOwn && m == `CC_M_CMP3) begin
            if (fire) begin
              out_r <= 1'b1;
            end else if (ov) begin
              out_r <= 1'b0;
            end
          end
        end
      end
      assign ccAll[i*16 +: 16] = val_r;
      assign fireV[i]  = fire;
      assign chEvt[i]  = cap | fire;
      assign pinOut[i] = out_r;
      assign pinOe[i]  = oe_r;
    end
  endgenerate

  // control registers
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      tctrl_r <= `CC_RST_TCTRL;
      mode0_r <= `CC_RST_WORD;
      mode1_r <= `CC_RST_WORD;
      dbl_r   <= `CC_RST_DBL;
      mask_r  <= `CC_RST_ST;
    end else if (wrAcc) begin
      if (isAddr(paddr, `CC_ADDR_TCTRL)) begin
        tctrl_r <= pwdata[15:0];
      end else if (isAddr(paddr, `CC_ADDR_MODE0)) begin
        mode0_r <= pwdata[15:0];
      end else if (isAddr(paddr, `CC_ADDR_MODE1)) begin
        mode1_r <= pwdata[15:0];
      end else if (isAddr(paddr, `CC_ADDR_DBL)) begin
        dbl_r <= pwdata[3:0];
      end else if (isAddr(paddr, `CC_ADDR_IRQMSK)) begin
        mask_r <= pwdata[`CC_ST_W-1:0];
      end
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  always @* begin
    status_nxt = status_r;
    if (wrAcc && isAddr(paddr, `CC_ADDR_IRQST)) begin
      status_nxt = status_r & ~pwdata[`CC_ST_W-1:0];
    end
    status_nxt = status_nxt | {ovf[1], ovf[0], chEvt};
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      status_r <= `CC_RST_ST;
      irq      <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq      <= |(status_r & mask_r);
    end
  end

  // read decode
  always @* begin
    rdData = 32'h00000000;
    rdErr  = 1'b0;
    if (isAddr(paddr, `CC_ADDR_TCTRL)) begin
      rdData = {16'h0000, tctrl_r};
    end else if (isAddr(paddr, `CC_ADDR_TB0CNT)) begin
      rdData = {16'h0000, cntAll[15:0]};
    end else if (isAddr(paddr, `CC_ADDR_TB0RLD)) begin
      rdData = {16'h0000, rldAll[15:0]};
    end else if (isAddr(paddr, `CC_ADDR_TB1CNT)) begin
      rdData = {16'h0000, cntAll[31:16]};
    end else if (isAddr(paddr, `CC_ADDR_TB1RLD)) begin
      rdData = {16'h0000, rldAll[31:16]};
    end else if (isAddr(paddr, `CC_ADDR_MODE0)) begin
      rdData = {16'h0000, mode0_r};
    end else if (isAddr(paddr, `CC_ADDR_MODE1)) begin
      rdData = {16'h0000, mode1_r};
    end else if (isAddr(paddr, `CC_ADDR_DBL)) begin
      rdData = {28'h0000000, dbl_r};
    end else if (paddr >= `CC_ADDR_CH0 && paddr <= `CC_ADDR_CH7 &&
                 paddr[1:0] == 2'h0) begin
      rdData = {16'h0000, ccAll[paddr[4:2]*16 +: 16]};
    end else if (isAddr(paddr, `CC_ADDR_IRQST)) begin
      rdData = {22'h000000, status_r};
    end else if (isAddr(paddr, `CC_ADDR_IRQMSK)) begin
      rdData = {22'h000000, mask_r};
    end else begin
      rdErr = 1'b1;
    end
  end

endmodule

/* pin_model.sv */
// far side of the channel pins: drives levels where the unit does not
`timescale 1ns/1ns
module pin_model (
  input  logic       ref_clk, // clock
  input  logic [7:0] pinOut,  // unit drive values
  input  logic [7:0] pinOe,   // unit drive enables
  output logic [7:0] pinIn    // resolved pin levels
);
  logic [7:0] extLevel;
  initial extLevel = 8'h00;
  assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
  // trigger edge on one pin, launched just after a clock edge
  task setPin(input int ch, input logic v);
    @(posedge ref_clk);
    extLevel[ch] <= v;
  endtask
endmodule

/* testbench.sv */
// self-checking bench for the capture/compare unit
`timescale 1ns/1ns
`include "cc_unit_defs.vh"
module testbench;
  logic        ref_clk = 1'b0, rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdat;
  wire  [31:0] prdata;
  wire  [7:0]  pinIn, pinOut, pinOe;
  wire         pready, pslverr, irq;
  logic        lastErr;
  int          failures = 0, n_checks = 0;
  eight_channel_cc_unit #(.RES_CYCLES(2)) dut (.ref_clk(ref_clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .irq(irq));
  pin_model pins (.ref_clk(ref_clk), .pinOut(pinOut), .pinOe(pinOe),
    .pinIn(pinIn));
  initial forever #5 ref_clk = ~ref_clk;
  task tally_and_finish();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge ref_clk); k++; end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin failures++; tally_and_finish(); end
    rdat = prdata; lastErr = pslverr; psel <= 1'b0; penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d); apb(a, 1'b1, d); endtask
  task rd(input logic [7:0] a); apb(a, 1'b0, 32'h0); endtask
  task resetRegs();
    rd(`CC_ADDR_TCTRL); check(rdat, 32'h0);
    rd(`CC_ADDR_IRQST); check(rdat, 32'h0);
    rd(8'h48); check(rdat, 32'h0); check(lastErr, 1'b1);
  endtask
  task capModes();
    logic [31:0] m, last;
    wr(`CC_ADDR_IRQMSK, 32'h1);
    for (m = 32'h1; m <= 32'h3; m++) begin
      wr(`CC_ADDR_MODE0, m); wr(`CC_ADDR_CH0, 32'h0);
      wr(`CC_ADDR_TB0CNT, 32'h0a00 + m); pins.setPin(0, 1'b1); idle(4);
      last = (m != 32'h2) ? 32'h0a00 + m : 32'h0;
      rd(`CC_ADDR_CH0); check(rdat, last);
      wr(`CC_ADDR_TB0CNT, 32'h0b00 + m); pins.setPin(0, 1'b0); idle(4);
      rd(`CC_ADDR_CH0); check(rdat, (m != 32'h1) ? 32'h0b00 + m : last);
    end
    check(irq, 1'b1);
    rd(`CC_ADDR_IRQST); check(rdat, 32'h1);
    wr(`CC_ADDR_IRQST, 32'h1); idle(3); check(irq, 1'b0);
  endtask
  task cmpRun();
    logic [7:0] prev;
    int i, n0, n1, r2, f2, n3;
    for (i = 0; i < 5; i++) wr(`CC_ADDR_CH0 + 8'(4 * i), 32'hfff2 + 2 * i);
    wr(`CC_ADDR_MODE0, 32'h4755); wr(`CC_ADDR_MODE1, 32'h4);
    wr(`CC_ADDR_DBL, 32'h1); wr(`CC_ADDR_TB0RLD, 32'hfff0);
    wr(`CC_ADDR_TB0CNT, 32'hfff0); wr(`CC_ADDR_TCTRL, 32'h1); idle(20);
    n0 = 0; n1 = 0; r2 = 0; f2 = 0; n3 = 0;
    @(negedge ref_clk);
    prev = pinOut;
    repeat (128) begin
      @(negedge ref_clk);
      n0 += int'(pinOut[0] !== prev[0]); n1 += int'(pinOut[1] !== prev[1]);
      r2 += int'(pinOut[2] & ~prev[2]); f2 += int'(~pinOut[2] & prev[2]);
      n3 += int'(pinOut[3] !== prev[3]); prev = pinOut;
    end
    check(n0, 8);
    check(n1, 4);
    check(r2, 4);
    check(f2, 4);
    check(n3, 0);
    check(pinOe, 8'h07);
    wr(`CC_ADDR_TCTRL, 32'h0); rd(`CC_ADDR_IRQST);
    check(rdat & 32'h11f, 32'h11f);
    wr(`CC_ADDR_IRQMSK, 32'h0);
  endtask
  initial begin
    idle(20);
    rst_n <= 1'b1;
    resetRegs();
    capModes();
    cmpRun();
    tally_and_finish();
  end
endmodule
bind eight_channel_cc_unit cc_unit_checker chk (.ref_clk(ref_clk),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
  .irq(irq));
